// >>> bench/crsi_core_monitor.sv
// Port-level checker for the core state and interrupt sequencer
`timescale 1ns/10ps
module crsi_core_monitor
  import crsi_pkg::*;
#(
  parameter int N_SRC = 8
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Core requests
  input wire crsi_stk_op_t stk_op,
  input wire logic io_wr,
  input wire logic cli,
  input wire logic sei,
  input wire logic return_from_interrupt,
  input wire logic instr_done,
  input wire logic sleeping,
  input wire logic [13:0] pc,
  input wire logic [N_SRC-1:0] src_enable,
  // Results
  input wire logic [15:0] stack_pointer,
  input wire logic stack_wr,
  input wire logic stack_rd,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata,
  input wire logic [7:0] status_register,
  input wire logic irq_taken,
  input wire logic vector_go,
  input wire logic pc_restore_go,
  input wire logic seq_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // --------------------------------
  // Helper state
  // --------------------------------
  logic [15:0] sp_take;
  logic ret_hold;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sp_take <= 16'h0000;
      ret_hold <= 1'b0;
    end else begin
      if (irq_taken) sp_take <= stack_pointer;
      if (instr_done) ret_hold <= 1'b0;
      else if (pc_restore_go) ret_hold <= 1'b1;
    end
  end
  // --------------------------------
  // Assertions
  // --------------------------------
  AST_TAKE_GIE: assert property (irq_taken |-> $past(status_register[7]) && !status_register[7])
    else $error("take without global enable or enable not cleared");
  AST_TAKE_EN: assert property (irq_taken |-> $past(src_enable) != '0)
    else $error("take with no source enabled");
  AST_CLI_NOW: assert property (cli |=> !irq_taken)
    else $error("take in the global disable cycle");
  AST_SEI_NEXT: assert property (sei && instr_done |=> !irq_taken)
    else $error("take before the instruction after enable");
  AST_RET_ONE: assert property (instr_done && (ret_hold || pc_restore_go) |=> !irq_taken)
    else $error("take before one instruction after return");
  AST_PUSH_PC: assert property (irq_taken |=> stack_wr && stack_addr == stack_pointer &&
    {6'h00, stack_wdata} == ($past(pc, 2) & 14'h00FF) ##1 stack_wr && stack_addr == $past(stack_addr) - 16'h0001)
    else $error("return address push wrong");
  AST_ENTRY_LEN: assert property (irq_taken && !$past(sleeping) |-> !vector_go[*4] ##1 vector_go)
    else $error("entry length wrong");
  AST_SLEEP_LEN: assert property (irq_taken && $past(sleeping) |-> !vector_go[*8] ##1 vector_go)
    else $error("entry from sleep length wrong");
  AST_ENTRY_SP: assert property (vector_go |-> stack_pointer == sp_take - 16'h0002)
    else $error("stack pointer not lowered by two on entry");
  AST_RET_SEQ: assert property (return_from_interrupt && instr_done && !seq_busy |=> ##1 stack_rd &&
    stack_addr == stack_pointer + 16'h0001 ##3 pc_restore_go && status_register[7])
    else $error("return sequence wrong");
  AST_RET_SP: assert property (pc_restore_go |-> stack_pointer == $past(stack_pointer, 5) + 16'h0002)
    else $error("stack pointer not raised by two on return");
  AST_PUSH1: assert property (stk_op == STK_PUSH1 && !seq_busy && !io_wr |=>
    stack_pointer == $past(stack_pointer) - 16'h0001)
    else $error("byte push step wrong");
  cover property (irq_taken ##4 vector_go);
  cover property (irq_taken ##8 vector_go);
  cover property (pc_restore_go);
endmodule

bind crsi_core crsi_core_monitor #(.N_SRC(N_SRC)) u_mon (
  .clk_sys, .rst_n, .stk_op, .io_wr, .cli, .sei, .return_from_interrupt, .instr_done, .sleeping, .pc, .src_enable,
  .stack_pointer, .stack_wr, .stack_rd, .stack_addr, .stack_wdata, .status_register, .irq_taken,
  .vector_go, .pc_restore_go, .seq_busy
);

// >>> bench/crsi_stack_ram.sv
// Behavioural data memory holding the stack beside the core
`timescale 1ns/10ps
module crsi_stack_ram (
  // Clock
  input wire logic clk_sys,
  // Stack bus
  input wire logic stack_wr,
  input wire logic stack_rd,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata,
  output logic [7:0] stack_rdata
);
  // Only the low address byte is decoded: the stack must stay in one 256-byte page
  logic [7:0] mem [256];
  initial stack_rdata = 8'h00;
  // Output toggles between reads so stale data is never taken for an answer
  always @(posedge clk_sys) begin
    if (stack_wr) mem[stack_addr[7:0]] <= stack_wdata;
    if (stack_rd) stack_rdata <= mem[stack_addr[7:0]];
    else stack_rdata <= ~stack_rdata;
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the core state and interrupt sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module testbench
  import crsi_pkg::*;
;
  logic clk_sys;
  logic rst_n = 0, wr_en = 0, wr_wide = 0, ptr_go = 0, ds_rd = 0, ds_wr = 0, io_rd = 0, io_wr = 0;
  logic instr_done = 0, sei = 0, cli = 0, return_from_interrupt = 0, sleeping = 0, alu_flags_we = 0;
  logic boot_reset_fuse = 0, app_lock_bit_two = 0, boot_lock_bit_two = 0;
  logic [4:0] rd_a_addr = 0, rd_b_addr = 0, wr_addr = 0;
  logic [3:0] rd_w_addr = 0;
  logic [15:0] wr_data = 0, ds_addr = 0;
  logic [1:0] ptr_sel = 0;
  logic [5:0] ptr_disp = 0, io_addr = 0;
  logic [7:0] ds_wdata = 0, io_wdata = 0, src_event = 0, src_level = 0, src_enable = 0, flag_clr = 0;
  logic [13:0] pc = 0;
  logic [6:0] alu_flags = 0;
  crsi_ptr_mode_t ptr_mode = PTR_PLAIN;
  crsi_stk_op_t stk_op = STK_NONE;
  wire logic [7:0] rd_a_data, rd_b_data, ds_rdata, io_rdata, stack_wdata, stack_rdata, status_register, irq_flags;
  wire logic [15:0] rd_w_data, ptr_addr, stack_pointer, stack_addr;
  wire logic [13:0] reset_vector, irq_vector, pc_restore;
  wire logic ds_hit, stack_wr, stack_rd, irq_taken, vector_go, pc_restore_go, seq_busy;
  int n_fail = 0;
  int cmp_count = 0;
  typedef struct {crsi_stk_op_t op; logic [15:0] sp;} crsi_row_t;
  crsi_row_t rows [4] = '{'{STK_PUSH1, 16'h015E}, '{STK_POP1, 16'h015F}, '{STK_PUSH2, 16'h015D},
    '{STK_POP2, 16'h015F}};

  crsi_core uut (.*);
  crsi_stack_ram u_ram (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic nx;
    @(posedge clk_sys);
  endtask
  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
    nx;
    io_addr <= a;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= !w;
    nx;
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask
  // One instruction boundary, optionally carrying enable or return
  task automatic ins(input logic s, input logic r);
    nx;
    instr_done <= 1'b1;
    sei <= s;
    return_from_interrupt <= r;
    nx;
    instr_done <= 1'b0;
    sei <= 1'b0;
    return_from_interrupt <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (12) nx;
    rst_n <= 1'b1;
    #1 `CHK(stack_pointer, SP_RESET)
    `CHK(status_register, STATUS_REGISTER_RESET)
    `CHK(reset_vector, 14'h0000)
    io(1'b0, IO_SP_HIGH, 8'h00);
    `CHK(io_rdata, 8'h00)
    io(1'b1, IO_SP_HIGH, 8'h01);
    io(1'b1, IO_SP_LOW, 8'h5F);
    io(1'b0, IO_SP_LOW, 8'h00);
    `CHK(io_rdata, 8'h5F)
    foreach (rows[i]) begin
      nx;
      stk_op <= rows[i].op;
      nx;
      stk_op <= STK_NONE;
      #1 `CHK(stack_pointer, rows[i].sp)
    end
    nx;
    wr_en <= 1'b1;
    wr_wide <= 1'b1;
    wr_addr <= 5'h1A;
    wr_data <= 16'h1234;
    nx;
    wr_en <= 1'b0;
    rd_w_addr <= 4'hD;
    rd_a_addr <= 5'h1A;
    rd_b_addr <= 5'h1B;
    ds_addr <= 16'h001B;
    ds_rd <= 1'b1;
    nx;
    ds_rd <= 1'b0;
    #1 `CHK(rd_w_data, 16'h1234)
    `CHK({rd_b_data, rd_a_data}, 16'h1234)
    `CHK({ds_hit, ds_rdata}, 9'h112)
    nx;
    ds_addr <= 16'h0005;
    ds_wdata <= 8'hA5;
    ds_wr <= 1'b1;
    nx;
    ds_wr <= 1'b0;
    rd_a_addr <= 5'h05;
    ptr_mode <= PTR_POSTINC;
    ptr_go <= 1'b1;
    nx;
    ptr_mode <= PTR_PREDEC;
    #1 `CHK(rd_a_data, 8'hA5)
    `CHK({ptr_addr, rd_w_data}, 32'h12341235)
    nx;
    ptr_go <= 1'b0;
    #1 `CHK({ptr_addr, rd_w_data}, 32'h12341234)
    // Enabled flag waits for global enable
    nx;
    pc <= 14'h0123;
    src_enable <= 8'h04;
    src_event <= 8'h04;
    alu_flags_we <= 1'b1;
    alu_flags <= 7'h55;
    nx;
    src_event <= 8'h00;
    alu_flags_we <= 1'b0;
    #1 `CHK(irq_flags, 8'h04)
    ins(1'b1, 1'b0);
    `CHK({irq_taken, status_register}, 9'h0D5)
    ins(1'b0, 1'b0);
    `CHK({irq_taken, status_register}, 9'h155)
    `CHK(irq_flags, 8'h00)
    nx;
    #1 `CHK(stack_wdata, 8'h23)
    repeat (3) nx;
    #1 `CHK({vector_go, irq_vector}, 15'h4006)
    `CHK(stack_pointer, 16'h015D)
    nx;
    alu_flags_we <= 1'b1;
    alu_flags <= 7'h2A;
    nx;
    alu_flags_we <= 1'b0;
    pc <= 14'h0200;
    ins(1'b0, 1'b1);
    repeat (4) nx;
    #1 `CHK({pc_restore_go, pc_restore}, 15'h4123)
    `CHK(status_register, 8'hAA)
    `CHK(stack_pointer, 16'h015F)
    ins(1'b0, 1'b0);
    nx;
    src_event <= 8'h0A;
    nx;
    src_event <= 8'h00;
    src_enable <= 8'h0A;
    cli <= 1'b1;
    instr_done <= 1'b1;
    nx;
    cli <= 1'b0;
    instr_done <= 1'b0;
    #1 `CHK(irq_taken, 1'b0)
    ins(1'b0, 1'b0);
    `CHK({irq_taken, irq_flags}, 9'h00A)
    ins(1'b1, 1'b0);
    ins(1'b0, 1'b0);
    `CHK({irq_taken, irq_flags}, 9'h108)
    repeat (3) nx;
    #1 `CHK(irq_vector, 14'h0004)
    io(1'b1, IO_GIRQ_CTRL, 8'h02);
    ins(1'b0, 1'b1);
    repeat (4) nx;
    ins(1'b0, 1'b0);
    `CHK(irq_taken, 1'b0)
    nx;
    sleeping <= 1'b1;
    ins(1'b0, 1'b0);
    `CHK(irq_taken, 1'b1)
    repeat (8) nx;
    sleeping <= 1'b0;
    #1 `CHK({vector_go, irq_vector}, 15'h7808)
    // Flag clearing by software, and a set that beats a clear
    nx;
    src_enable <= 8'h00;
    src_event <= 8'h10;
    nx;
    src_event <= 8'h00;
    flag_clr <= 8'h10;
    nx;
    src_event <= 8'h20;
    flag_clr <= 8'h20;
    nx;
    src_event <= 8'h00;
    flag_clr <= 8'h00;
    #1 `CHK(irq_flags, 8'h20)
    ins(1'b1, 1'b0);
    ins(1'b0, 1'b0);
    `CHK(irq_taken, 1'b0)
    nx;
    boot_reset_fuse <= 1'b1;
    repeat (2) nx;
    #1 `CHK(reset_vector, 14'h3800)
    report_and_stop;
  end
endmodule

// >>> core/crsi_core.sv
// Core state: register file, pointers, stack pointer and interrupt sequencing
//
// What this block does
// - Register file offers 8/8, 2x8/8, 2x8/16 and 16/16 read/write patterns.
// - All 32 registers also answer at data addresses 0 to 31.
// - Registers 26..31 form three pointers, even register low byte.
// - Pointers support displacement, post-increment and pre-decrement with writeback.
// - Stack grows down; byte push/pop step 1, calls/returns/interrupts step 2.
// - Stack pointer is two 8-bit I/O registers, reset to zero.
// - Core runs straight from the chip clock, undivided.
// - Two operands read, computed and written back in one cycle.
// - Next instruction is fetched while the current one executes.
// - Source served only when its enable and global enable are set.
// - Boot lock bits can suppress interrupts depending on program counter.
// - Vectors sit at lowest addresses; lower address means higher priority.
// - Vector-select bit moves the vector table to the boot section.
// - Boot-reset fuse moves the reset vector to the boot section.
// - Accepting clears global enable; return-from-interrupt sets it again.
// - Vectoring clears a flag; writing one to a flag also clears it.
// - Flags stay pending while disabled, then serve in priority order.
// - Level sources request only while their condition is present.
// - After return, one instruction runs before any pending interrupt.
// - Global disable acts at once, even against a same-cycle request.
// - Status register is never saved or restored by hardware.
// - Entry takes four cycles pushing PC, eight from sleep; return four.
// - Multi-cycle instructions finish before interrupt entry starts.
// - The instruction after global enable runs before any pending interrupt.
// - Global enable lives in status bit 7 and gates every source.
`timescale 1ns/10ps
module crsi_core
  import crsi_pkg::*;
#(
  parameter int N_SRC = 8,
  parameter logic [N_SRC-1:0] LEVEL_MASK = '0,
  parameter logic [13:0] BOOT_START = 14'h3800,
  parameter logic [13:0] VEC_STEP = 14'h0002
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register file core port
  input wire logic [4:0] rd_a_addr,
  input wire logic [4:0] rd_b_addr,
  output logic [7:0] rd_a_data,
  output logic [7:0] rd_b_data,
  input wire logic [3:0] rd_w_addr,
  output logic [15:0] rd_w_data,
  input wire logic wr_en,
  input wire logic wr_wide,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Pointer unit
  input wire logic ptr_go,
  input wire logic [1:0] ptr_sel,
  input wire crsi_ptr_mode_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_addr,
  // Data space
  input wire logic [15:0] ds_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_hit,
  // I/O space
  input wire logic [5:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Stack
  input wire crsi_stk_op_t stk_op,
  output logic [15:0] stack_pointer,
  output logic stack_wr,
  output logic stack_rd,
  output logic [15:0] stack_addr,
  output logic [7:0] stack_wdata,
  input wire logic [7:0] stack_rdata,
  // Program flow
  input wire logic instr_done,
  input wire logic sei,
  input wire logic cli,
  input wire logic return_from_interrupt,
  input wire logic sleeping,
  input wire logic [13:0] pc,
  input wire logic alu_flags_we,
  input wire logic [6:0] alu_flags,
  output logic [7:0] status_register,
  // Fuses and lock bits
  input wire logic boot_reset_fuse,
  input wire logic app_lock_bit_two,
  input wire logic boot_lock_bit_two,
  output logic [13:0] reset_vector,
  // Interrupt sources
  input wire logic [N_SRC-1:0] src_event,
  input wire logic [N_SRC-1:0] src_level,
  input wire logic [N_SRC-1:0] src_enable,
  input wire logic [N_SRC-1:0] flag_clr,
  output logic [N_SRC-1:0] irq_flags,
  // Sequencer results
  output logic irq_taken,
  output logic [13:0] irq_vector,
  output logic vector_go,
  output logic [13:0] pc_restore,
  output logic pc_restore_go,
  output logic seq_busy
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] ptr_val;
  logic [7:0] rf_ds_rdata;
  wire ds_in_rf = ds_addr < REG_SPACE_TOP;
  wire [15:0] ptr_inc = ptr_val + 16'h0001;
  wire [15:0] ptr_dec = ptr_val - 16'h0001;
  wire [15:0] ptr_dsp = ptr_val + {10'h000, ptr_disp};
  wire ptr_we = ptr_go && (ptr_mode == PTR_POSTINC || ptr_mode == PTR_PREDEC);
  wire [15:0] ptr_wdata = (ptr_mode == PTR_POSTINC) ? ptr_inc : ptr_dec;
  wire [15:0] ptr_eff = (ptr_mode == PTR_PREDEC) ? ptr_dec :
                        (ptr_mode == PTR_DISP) ? ptr_dsp : ptr_val;

  crsi_regfile u_regfile (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rd_a_addr(rd_a_addr),
    .rd_b_addr(rd_b_addr),
    .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data),
    .rd_w_addr(rd_w_addr),
    .rd_w_data(rd_w_data),
    .wr_en(wr_en),
    .wr_wide(wr_wide),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .ptr_sel(ptr_sel),
    .ptr_val(ptr_val),
    .ptr_we(ptr_we),
    .ptr_wdata(ptr_wdata),
    .ds_addr(ds_addr[4:0]),
    .ds_rdata(rf_ds_rdata),
    .ds_we(ds_wr && ds_in_rf),
    .ds_wdata(ds_wdata)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr_addr <= 16'h0000;
      ds_rdata <= 8'h00;
      ds_hit <= 1'b0;
    end else begin
      if (ptr_go) ptr_addr <= ptr_eff;
      if (ds_rd) ds_rdata <= ds_in_rf ? rf_ds_rdata : 8'h00;
      ds_hit <= (ds_rd || ds_wr) && ds_in_rf;
    end
  end

  // ----------------------------------------
  // Interrupt request and priority
  // ----------------------------------------
  crsi_state_t state, next_state;
  logic [3:0] cnt;
  logic [3:0] entry_len;
  logic hold_one;
  logic [7:0] general_irq_control;
  logic [13:0] pc_saved;
  logic [7:0] ret_hi;

  wire gie = status_register[GIE_BIT];
  wire vector_table_select = general_irq_control[VECTOR_TABLE_SELECT_BIT];
  wire [N_SRC-1:0] req_flag = irq_flags & ~LEVEL_MASK;
  wire [N_SRC-1:0] req_level = src_level & LEVEL_MASK;
  wire [N_SRC-1:0] req = (req_flag | req_level) & src_enable;
  wire in_boot = pc >= BOOT_START;
  // Lock bits only block service from the section the vectors do not sit in
  wire lock_block = (app_lock_bit_two && !in_boot && vector_table_select) ||
                    (boot_lock_bit_two && in_boot && !vector_table_select);
  wire io_status_register_wr = io_wr && (io_addr == IO_STATUS);

  logic [N_SRC-1:0] win;
  logic [13:0] win_idx;
  always_comb begin
    win = '0;
    win_idx = 14'h0000;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        win = '0;
        win[i] = 1'b1;
        win_idx = 14'(i);
      end
    end
  end

  // Lowest index is served first and owns the lowest vector after reset
  wire [13:0] vec_base = vector_table_select ? BOOT_START : 14'h0000;
  wire [13:0] vec_addr = vec_base + VEC_STEP * (win_idx + 14'h0001);

  // Boundary-only acceptance, so multi-cycle instructions always finish first
  wire take = (state == ST_IDLE) && instr_done && gie && !cli && !io_status_register_wr &&
              !hold_one && !lock_block && (|req);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  wire entry_last = (state == ST_ENTRY) && (cnt == entry_len - 4'h1);
  wire ret_last = (state == ST_RETURN) && (cnt == RETURN_CYCLES - 4'h1);
  wire ret_start = (state == ST_IDLE) && return_from_interrupt && !take;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) next_state = ST_ENTRY;
        else if (ret_start) next_state = ST_RETURN;
      end
      ST_ENTRY: if (entry_last) next_state = ST_IDLE;
      ST_RETURN: if (ret_last) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      entry_len <= ENTRY_CYCLES;
      pc_saved <= 14'h0000;
    end else begin
      state <= next_state;
      cnt <= (state == next_state) ? cnt + 4'h1 : 4'h0;
      if (take) begin
        // Waking from sleep costs four more cycles before the vector runs
        entry_len <= sleeping ? ENTRY_CYCLES + SLEEP_EXTRA : ENTRY_CYCLES;
        pc_saved <= pc;
      end
    end
  end

  // One instruction after a return before the next entry; after the enable the
  // old enable bit already blocks the enabling instruction's own boundary
  always_ff @(posedge clk_sys) begin
    if (!rst_n) hold_one <= 1'b0;
    else if (ret_last) hold_one <= 1'b1;
    else if (instr_done) hold_one <= 1'b0;
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  wire [N_SRC-1:0] hw_clr = take ? win : '0;
  // Clearing first, then the new event, so an event in the clear cycle survives
  wire [N_SRC-1:0] next_flags = ((irq_flags & ~(flag_clr | hw_clr)) | src_event) & ~LEVEL_MASK;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) irq_flags <= '0;
    else irq_flags <= next_flags;
  end

  // ----------------------------------------
  // Status and control registers
  // ----------------------------------------
  // Only the enable bit is touched by sequencing; other bits are left to software
  logic [7:0] next_status_register;
  always_comb begin
    next_status_register = status_register;
    if (alu_flags_we) next_status_register[6:0] = alu_flags;
    if (io_status_register_wr) next_status_register = io_wdata;
    if (sei) next_status_register[GIE_BIT] = 1'b1;
    if (cli) next_status_register[GIE_BIT] = 1'b0;
    if (take) next_status_register[GIE_BIT] = 1'b0;
    if (ret_last) next_status_register[GIE_BIT] = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_register <= STATUS_REGISTER_RESET;
      general_irq_control <= 8'h00;
      reset_vector <= 14'h0000;
    end else begin
      status_register <= next_status_register;
      if (io_wr && io_addr == IO_GIRQ_CTRL) general_irq_control <= io_wdata & (8'h01 << VECTOR_TABLE_SELECT_BIT);
      reset_vector <= boot_reset_fuse ? BOOT_START : 14'h0000;
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  logic [15:0] next_sp;
  always_comb begin
    next_sp = stack_pointer;
    if (entry_last) next_sp = stack_pointer - SP_STEP2;
    else if (ret_last) next_sp = stack_pointer + SP_STEP2;
    else if (state == ST_IDLE) begin
      case (stk_op)
        STK_PUSH1: next_sp = stack_pointer - SP_STEP1;
        STK_POP1: next_sp = stack_pointer + SP_STEP1;
        STK_PUSH2: next_sp = stack_pointer - SP_STEP2;
        STK_POP2: next_sp = stack_pointer + SP_STEP2;
        default: next_sp = stack_pointer;
      endcase
    end
    if (io_wr && io_addr == IO_SP_LOW) next_sp[7:0] = io_wdata;
    if (io_wr && io_addr == IO_SP_HIGH) next_sp[15:8] = io_wdata;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) stack_pointer <= SP_RESET;
    else stack_pointer <= next_sp;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) io_rdata <= 8'h00;
    else if (io_rd) begin
      case (io_addr)
        IO_SP_LOW: io_rdata <= stack_pointer[7:0];
        IO_SP_HIGH: io_rdata <= stack_pointer[15:8];
        IO_STATUS: io_rdata <= status_register;
        IO_GIRQ_CTRL: io_rdata <= general_irq_control;
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Stack traffic during entry and return
  // ----------------------------------------
  // Entry pushes the return address low byte first; return pops high byte first
  wire push_lo = (state == ST_ENTRY) && (cnt == 4'h0);
  wire push_hi = (state == ST_ENTRY) && (cnt == 4'h1);
  wire pop_hi = (state == ST_RETURN) && (cnt == 4'h0);
  wire pop_lo = (state == ST_RETURN) && (cnt == 4'h1);
  wire [15:0] next_saddr = push_hi ? stack_pointer - SP_STEP1 :
                           pop_hi ? stack_pointer + SP_STEP1 :
                           pop_lo ? stack_pointer + SP_STEP2 : stack_pointer;
  wire [7:0] next_swdata = push_hi ? {2'b00, pc_saved[13:8]} : pc_saved[7:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stack_wr <= 1'b0;
      stack_rd <= 1'b0;
      stack_addr <= 16'h0000;
      stack_wdata <= 8'h00;
      ret_hi <= 8'h00;
      pc_restore <= 14'h0000;
      pc_restore_go <= 1'b0;
    end else begin
      stack_wr <= push_lo || push_hi;
      stack_rd <= pop_hi || pop_lo;
      stack_addr <= next_saddr;
      stack_wdata <= next_swdata;
      // Read data follows its strobe by one cycle
      if ((state == ST_RETURN) && (cnt == 4'h2)) ret_hi <= stack_rdata;
      if (ret_last) pc_restore <= {ret_hi[5:0], stack_rdata};
      pc_restore_go <= ret_last;
    end
  end

  // ----------------------------------------
  // Vector outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_taken <= 1'b0;
      irq_vector <= 14'h0000;
      vector_go <= 1'b0;
    end else begin
      irq_taken <= take;
      if (take) irq_vector <= vec_addr;
      vector_go <= entry_last;
    end
  end

  assign seq_busy = state != ST_IDLE;
endmodule

// >>> core/crsi_pkg.sv
// Shared constants and types for the core state and interrupt sequencer
package crsi_pkg;
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  localparam int NUM_REGS = 32;
  localparam logic [3:0] PTR_BASE_PAIR = 4'hD;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] REG_SPACE_TOP = 16'h0020;
  // ----------------------------------------
  // I/O space map
  // ----------------------------------------
  localparam logic [5:0] IO_GIRQ_CTRL = 6'h3B;
  localparam logic [5:0] IO_SP_LOW = 6'h3D;
  localparam logic [5:0] IO_SP_HIGH = 6'h3E;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  localparam int GIE_BIT = 7;
  localparam int VECTOR_TABLE_SELECT_BIT = 1;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
  // ----------------------------------------
  // Sequencing, in CPU clock cycles
  // ----------------------------------------
  localparam logic [3:0] ENTRY_CYCLES = 4'h4;
  localparam logic [3:0] SLEEP_EXTRA = 4'h4;
  localparam logic [3:0] RETURN_CYCLES = 4'h4;
  localparam logic [15:0] SP_STEP1 = 16'h0001;
  localparam logic [15:0] SP_STEP2 = 16'h0002;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {STK_NONE, STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2} crsi_stk_op_t;
  typedef enum logic [1:0] {PTR_PLAIN, PTR_DISP, PTR_POSTINC, PTR_PREDEC} crsi_ptr_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_RETURN} crsi_state_t;
endpackage

// >>> core/crsi_regfile.sv
// Thirty-two byte working register file with core, pointer and data-space write ports
`timescale 1ns/10ps
module crsi_regfile
  import crsi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Core read ports
  input wire logic [4:0] rd_a_addr,
  input wire logic [4:0] rd_b_addr,
  output logic [7:0] rd_a_data,
  output logic [7:0] rd_b_data,
  input wire logic [3:0] rd_w_addr,
  output logic [15:0] rd_w_data,
  // Core write port
  input wire logic wr_en,
  input wire logic wr_wide,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Pointer port
  input wire logic [1:0] ptr_sel,
  output logic [15:0] ptr_val,
  input wire logic ptr_we,
  input wire logic [15:0] ptr_wdata,
  // Data-space port
  input wire logic [4:0] ds_addr,
  output logic [7:0] ds_rdata,
  input wire logic ds_we,
  input wire logic [7:0] ds_wdata
);
  logic [7:0] regs [NUM_REGS];
  wire [3:0] ptr_pair = PTR_BASE_PAIR + 4'(ptr_sel);

  // Reads are combinational so operand fetch, ALU and writeback fit one cycle
  assign rd_a_data = regs[rd_a_addr];
  assign rd_b_data = regs[rd_b_addr];
  assign rd_w_data = {regs[{rd_w_addr, 1'b1}], regs[{rd_w_addr, 1'b0}]};
  assign ptr_val = {regs[{ptr_pair, 1'b1}], regs[{ptr_pair, 1'b0}]};
  assign ds_rdata = regs[ds_addr];

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    localparam logic [4:0] IDX = 5'(i);
    wire hit_core = wr_en && (wr_wide ? (wr_addr[4:1] == IDX[4:1]) : (wr_addr == IDX));
    wire [7:0] core_byte = (wr_wide && IDX[0]) ? wr_data[15:8] : wr_data[7:0];
    wire hit_ptr = ptr_we && (ptr_pair == IDX[4:1]);
    wire [7:0] ptr_byte = IDX[0] ? ptr_wdata[15:8] : ptr_wdata[7:0];
    wire hit_ds = ds_we && (ds_addr == IDX);
    // Core writeback wins over a pointer update, which wins over a data-space store
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        regs[i] <= REG_RESET;
      end else if (hit_core) begin
        regs[i] <= core_byte;
      end else if (hit_ptr) begin
        regs[i] <= ptr_byte;
      end else if (hit_ds) begin
        regs[i] <= ds_wdata;
      end
    end
  end
endmodule
